// *** rtl/tsr_pkg.sv ***
package tsr_pkg;
  // Serial frame: header byte {write, 4'h0, page}, address byte, data byte.
  localparam int FRAME_BITS = 24;
  localparam int PAGE_W = 3;
  localparam int WRITE_BIT = 23;
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam logic [4:0] HDR_BITS = 5'h10;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [3:0] HDR_PAD = 4'h0;
  localparam logic [7:0] DATA_PAD = 8'h00;

  // Register pages and offsets.
  localparam logic [2:0] PAGE_RESULT = 3'h2;
  localparam logic [2:0] PAGE_MODE = 3'h4;
  localparam logic [2:0] PAGE_ANALOG = 3'h6;
  localparam logic [7:0] ADDR_TEMP_HIGH = 8'h0A;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h0B;
  localparam logic [7:0] ADDR_TRIGGER = 8'h18;
  localparam logic [7:0] ADDR_MODE = 8'h12;
  localparam logic [7:0] ADDR_SET_A = 8'h13;
  localparam logic [7:0] ADDR_SET_B = 8'h15;
  localparam logic [7:0] ADDR_CAL = 8'h19;

  // Register values.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [7:0] MODE_GRAYSCALE = 8'hC0;
  localparam logic [7:0] TRIGGER_GO = 8'h01;
  localparam logic [7:0] MODE_ULTRA_FAST_SUM = 8'h10;
  localparam logic [7:0] MODE_BINNED_GRAY = 8'h20;

  // Temperature result.
  localparam int TEMP_W = 14;
  localparam logic [TEMP_W-1:0] TEMP_RESET = 14'h0000;
  localparam int SHIFT_UFS = 2;
  localparam int SHIFT_GBI = 1;
  localparam logic [2:0] ROWS_UFS = 3'h1;
  localparam logic [2:0] ROWS_GBI = 3'h2;
  localparam logic [2:0] ROWS_OTHER = 3'h4;
  localparam logic [1:0] HIGH_PAD = 2'h0;

  // Host arithmetic: calibration scale 1/4.7 as 10/47, filter gain 0.1 as 1/10.
  localparam logic [11:0] CAL_DIV_NUM = 12'h00A;
  localparam logic [11:0] CAL_DIV_DEN = 12'h02F;
  localparam logic [15:0] CAL_NORM_OFFSET = 16'h012B;
  localparam logic signed [15:0] FILT_DEN = 16'sh000A;
  localparam logic [7:0] SENS_FACTOR_X10 = 8'h19;

  // Serial clock timing at a 40 ns system clock.
  localparam int CLK_NS = 40;
  localparam int SPI_HALF_NS = 80;
  localparam int SPI_HALF_CYC = (SPI_HALF_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [3:0] {
    STEP_RD_A = 4'h0,
    STEP_RD_B = 4'h1,
    STEP_RD_CAL = 4'h2,
    STEP_RD_MODE = 4'h3,
    STEP_WR_GRAY = 4'h4,
    STEP_TRIGGER = 4'h5,
    STEP_RD_HIGH = 4'h6,
    STEP_RD_LOW = 4'h7,
    STEP_WR_A = 4'h8,
    STEP_WR_B = 4'h9,
    STEP_WR_MODE = 4'hA
  } tsr_step_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_XFER = 2'h1,
    SEQ_ROWS = 2'h2
  } tsr_seq_t;
endpackage

// *** rtl/tsr_spi_if.sv ***
`timescale 1ns/100ps
interface tsr_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport device (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// *** rtl/tsr_device.sv ***
`timescale 1ns/100ps
module tsr_device
  import tsr_pkg::*;
#(
  parameter logic [7:0] CAL_FACTORY = 8'h80
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Serial register port.
  tsr_spi_if.device SPI,
  // Sensor and readout events.
  input wire logic FRAME_START,
  input wire logic ROW_PAIR_DONE,
  input wire logic [TEMP_W-1:0] SENSOR_TEMP,
  // Acquisition control.
  output logic ACQ_TRIGGER,
  output logic LOW_SENSITIVITY,
  output logic TEMP_READY,
  output logic [7:0] MODE,
  output logic [7:0] SETTING_A,
  output logic [7:0] SETTING_B
);
  logic sclk_q;
  logic [4:0] bit_cnt;
  logic [22:0] sr;
  logic load_q;
  logic [7:0] rd_shift;
  logic [7:0] cal;
  logic [7:0] trigger;
  logic [TEMP_W-1:0] temp_value;
  logic [7:0] low_snap;
  logic [2:0] row_cnt;

  wire sclk_rise = SPI.sclk & ~sclk_q & ~SPI.cs_n;
  wire sclk_fall = ~SPI.sclk & sclk_q & ~SPI.cs_n;
  wire hdr_done = sclk_rise && (bit_cnt == HDR_LAST);
  wire frame_done = sclk_rise && (bit_cnt == FRAME_LAST);
  wire [15:0] hdr = load_q ? sr[15:0] : sr[22:7];
  wire [2:0] page = hdr[8+PAGE_W-1:8];
  wire [7:0] addr = hdr[7:0];
  wire is_write = sr[22];
  wire [7:0] wdata = {sr[6:0], SPI.mosi};
  wire wr_en = frame_done && is_write;

  wire sel_high = (page == PAGE_RESULT) && (addr == ADDR_TEMP_HIGH);
  wire sel_low = (page == PAGE_RESULT) && (addr == ADDR_TEMP_LOW);
  wire sel_trig = (page == PAGE_RESULT) && (addr == ADDR_TRIGGER);
  wire sel_mode = (page == PAGE_MODE) && (addr == ADDR_MODE);
  wire sel_a = (page == PAGE_ANALOG) && (addr == ADDR_SET_A);
  wire sel_b = (page == PAGE_ANALOG) && (addr == ADDR_SET_B);
  wire sel_cal = (page == PAGE_ANALOG) && (addr == ADDR_CAL);

  // High byte carries the upper result bits, unused bits read zero.
  wire [7:0] temp_high_value = {HIGH_PAD, temp_value[TEMP_W-1:8]};
  wire [7:0] temp_low_value = temp_value[7:0];

  wire [7:0] rd_data = sel_high ? temp_high_value :
                       sel_low ? low_snap :
                       sel_trig ? trigger :
                       sel_mode ? MODE :
                       sel_a ? SETTING_A :
                       sel_b ? SETTING_B :
                       sel_cal ? cal : RD_UNMAPPED;

  wire ultra_fast_sum_mode = (MODE == MODE_ULTRA_FAST_SUM);
  wire binned_grayscale_mode = (MODE == MODE_BINNED_GRAY);
  wire [2:0] rows_need = ultra_fast_sum_mode ? ROWS_UFS :
                         binned_grayscale_mode ? ROWS_GBI : ROWS_OTHER;
  // Quarter value in the fast sum mode, half in binned mode, else full.
  wire [TEMP_W-1:0] temp_scaled = ultra_fast_sum_mode ? (SENSOR_TEMP >> SHIFT_UFS) :
                                  binned_grayscale_mode ? (SENSOR_TEMP >> SHIFT_GBI) :
                                  SENSOR_TEMP;
  wire temp_capture = ROW_PAIR_DONE && (row_cnt < rows_need) &&
                      ((row_cnt + 3'h1) == rows_need);

  assign SPI.miso = rd_shift[7];

  // Serial shifter; data leaves most significant bit first.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_q <= 1'b0;
      bit_cnt <= 5'h00;
      sr <= 23'h000000;
      load_q <= 1'b0;
      rd_shift <= 8'h00;
    end else begin
      sclk_q <= SPI.sclk;
      load_q <= hdr_done;
      if (SPI.cs_n) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
        bit_cnt <= bit_cnt + 5'h01;
        sr <= {sr[21:0], SPI.mosi};
      end
      if (load_q) begin
        rd_shift <= rd_data;
      end else if (sclk_fall && (bit_cnt > HDR_BITS)) begin
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
    end
  end

  // Writable registers. The calibration copy returns to the factory value on reset.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MODE <= REG_RESET;
      SETTING_A <= REG_RESET;
      SETTING_B <= REG_RESET;
      trigger <= REG_RESET;
      cal <= CAL_FACTORY;
    end else if (wr_en) begin
      if (sel_mode) MODE <= wdata;
      if (sel_a) SETTING_A <= wdata;
      if (sel_b) SETTING_B <= wdata;
      if (sel_trig) trigger <= wdata;
      if (sel_cal) cal <= wdata;
    end
  end

  // A trigger write with grayscale mode selected starts the reduced-sensitivity image.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ACQ_TRIGGER <= 1'b0;
      LOW_SENSITIVITY <= 1'b0;
    end else begin
      ACQ_TRIGGER <= wr_en && sel_trig && (wdata == TRIGGER_GO);
      if (wr_en && sel_trig && (wdata == TRIGGER_GO)) begin
        LOW_SENSITIVITY <= (MODE == MODE_GRAYSCALE);
      end else if (wr_en && sel_mode) begin
        LOW_SENSITIVITY <= 1'b0;
      end
    end
  end

  // Result is cleared at frame start and taken once enough row pairs are read.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      temp_value <= TEMP_RESET;
      row_cnt <= 3'h0;
      TEMP_READY <= 1'b0;
    end else if (FRAME_START) begin
      temp_value <= TEMP_RESET;
      row_cnt <= 3'h0;
      TEMP_READY <= 1'b0;
    end else if (temp_capture) begin
      temp_value <= temp_scaled;
      row_cnt <= row_cnt + 3'h1;
      TEMP_READY <= 1'b1;
    end else if (ROW_PAIR_DONE && (row_cnt < rows_need)) begin
      row_cnt <= row_cnt + 3'h1;
    end
  end

  // Reading the high byte freezes the low byte so the pair stays coherent.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      low_snap <= REG_RESET;
    end else if (load_q && !sr[15] && sel_high) begin
      low_snap <= temp_low_value;
    end
  end
endmodule

// *** rtl/tsr_host.sv ***
// Contract
// - Device clears temperature at each frame start.
// - Temperature scaled /4, /2 or full by mode.
// - Read result after mode's required row pairs.
// - Result sits at page 2, bytes 0x0A/0x0B.
// - Calibration restored from storage on every reset.
// - Temperature image taken at reduced sensitivity.
// - Save mode, write grayscale, then trigger image.
// - Afterwards restore analog settings and mode.
// - At start save settings, normalise calibration byte.
// - Read temperature high byte before low byte.
// - Smooth readings with gain 0.1, seeded first.
// - Stretch grayscale integration by 2.5 if needed.
// - Registers over serial port, MSB first.
`timescale 1ns/100ps
module tsr_host
  import tsr_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Serial register port.
  tsr_spi_if.host SPI,
  // Sequence requests.
  input wire logic INIT_REQ,
  input wire logic TEMP_REQ,
  input wire logic ROW_READ,
  // Results.
  output logic BUSY,
  output logic TEMP_VALID,
  output logic [TEMP_W-1:0] TEMP_RAW,
  output logic [TEMP_W-1:0] TEMP_FILT,
  output logic [15:0] CAL_NORM,
  output logic [7:0] GRAY_INTEG_X10
);
  tsr_seq_t state;
  tsr_step_t step;
  logic go;
  logic done;
  logic [1:0] half_cnt;
  logic [4:0] bit_cnt;
  logic [FRAME_BITS-1:0] tx;
  logic [7:0] rx;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic [2:0] rows;
  logic [7:0] save_a;
  logic [7:0] save_b;
  logic [7:0] save_mode;
  logic [7:0] temp_hi;
  logic seeded;
  logic step_wr;
  logic [2:0] step_page;
  logic [7:0] step_addr;
  logic [7:0] step_data;

  // Sequence table: one serial transfer per step.
  always_comb begin
    step_wr = 1'b0;
    step_page = PAGE_ANALOG;
    step_addr = ADDR_SET_A;
    step_data = DATA_PAD;
    case (step)
      STEP_RD_A: step_addr = ADDR_SET_A;
      STEP_RD_B: step_addr = ADDR_SET_B;
      STEP_RD_CAL: step_addr = ADDR_CAL;
      STEP_RD_MODE: begin
        step_page = PAGE_MODE;
        step_addr = ADDR_MODE;
      end
      STEP_WR_GRAY: begin
        step_wr = 1'b1;
        step_page = PAGE_MODE;
        step_addr = ADDR_MODE;
        step_data = MODE_GRAYSCALE;
      end
      STEP_TRIGGER: begin
        step_wr = 1'b1;
        step_page = PAGE_RESULT;
        step_addr = ADDR_TRIGGER;
        step_data = TRIGGER_GO;
      end
      STEP_RD_HIGH: begin
        step_page = PAGE_RESULT;
        step_addr = ADDR_TEMP_HIGH;
      end
      STEP_RD_LOW: begin
        step_page = PAGE_RESULT;
        step_addr = ADDR_TEMP_LOW;
      end
      STEP_WR_A: begin
        step_wr = 1'b1;
        step_data = save_a;
      end
      STEP_WR_B: begin
        step_wr = 1'b1;
        step_addr = ADDR_SET_B;
        step_data = save_b;
      end
      STEP_WR_MODE: begin
        step_wr = 1'b1;
        step_page = PAGE_MODE;
        step_addr = ADDR_MODE;
        step_data = save_mode;
      end
      default: step_wr = 1'b0;
    endcase
  end

  wire [FRAME_BITS-1:0] frame_word = {step_wr, HDR_PAD, step_page, step_addr, step_data};
  wire half_end = (half_cnt == 2'(SPI_HALF_CYC - 1));
  wire [11:0] cal_x10 = 12'({4'h0, rx} * CAL_DIV_NUM);
  wire [11:0] cal_q = cal_x10 / CAL_DIV_DEN;
  wire [TEMP_W-1:0] temp_now = {temp_hi[TEMP_W-9:0], rx};
  wire signed [15:0] filt_diff = $signed({2'h0, temp_now}) - $signed({2'h0, TEMP_FILT});
  wire signed [15:0] filt_step = filt_diff / FILT_DEN;
  wire [15:0] filt_next = 16'($signed({2'h0, TEMP_FILT}) + filt_step);
  wire last_step = (step == STEP_RD_CAL) || (step == STEP_WR_MODE);

  assign SPI.sclk = sclk;
  assign SPI.cs_n = cs_n;
  assign SPI.mosi = mosi;
  assign BUSY = (state != SEQ_IDLE);

  // Serial engine: mode 0, header and data sent MSB first.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cs_n <= 1'b1;
      sclk <= 1'b0;
      mosi <= 1'b0;
      tx <= 24'h000000;
      rx <= 8'h00;
      half_cnt <= 2'h0;
      bit_cnt <= 5'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cs_n) begin
        if (go) begin
          cs_n <= 1'b0;
          tx <= frame_word;
          mosi <= frame_word[WRITE_BIT];
          half_cnt <= 2'h0;
          bit_cnt <= 5'h00;
        end
      end else if (!half_end) begin
        half_cnt <= half_cnt + 2'h1;
      end else begin
        half_cnt <= 2'h0;
        sclk <= ~sclk;
        if (!sclk) begin
          rx <= {rx[6:0], SPI.miso};
        end else if (bit_cnt == FRAME_LAST) begin
          cs_n <= 1'b1;
          done <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 5'h01;
          tx <= {tx[FRAME_BITS-2:0], 1'b0};
          mosi <= tx[FRAME_BITS-2];
        end
      end
    end
  end

  // Step sequencer. The wait state holds off the result reads until row pairs are done.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= SEQ_IDLE;
      step <= STEP_RD_A;
      go <= 1'b0;
      rows <= 3'h0;
    end else begin
      go <= 1'b0;
      case (state)
        SEQ_IDLE: begin
          if (INIT_REQ) begin
            step <= STEP_RD_A;
            state <= SEQ_XFER;
            go <= 1'b1;
          end else if (TEMP_REQ) begin
            step <= STEP_RD_MODE;
            state <= SEQ_XFER;
            go <= 1'b1;
          end
        end
        SEQ_XFER: begin
          if (done) begin
            if (last_step) begin
              state <= SEQ_IDLE;
            end else if (step == STEP_TRIGGER) begin
              rows <= 3'h0;
              state <= SEQ_ROWS;
            end else begin
              step <= tsr_step_t'(step + 4'h1);
              go <= 1'b1;
            end
          end
        end
        SEQ_ROWS: begin
          // Grayscale mode is selected here, so the full row-pair count applies.
          if (ROW_READ) begin
            if (rows == ROWS_OTHER - 3'h1) begin
              step <= STEP_RD_HIGH;
              state <= SEQ_XFER;
              go <= 1'b1;
            end else begin
              rows <= rows + 3'h1;
            end
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  // Captured bytes and derived results.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      save_a <= REG_RESET;
      save_b <= REG_RESET;
      save_mode <= REG_RESET;
      temp_hi <= REG_RESET;
      CAL_NORM <= 16'h0000;
      TEMP_RAW <= TEMP_RESET;
      TEMP_FILT <= TEMP_RESET;
      TEMP_VALID <= 1'b0;
      seeded <= 1'b0;
      GRAY_INTEG_X10 <= 8'h00;
    end else begin
      TEMP_VALID <= 1'b0;
      if (done && (state == SEQ_XFER)) begin
        case (step)
          STEP_RD_A: save_a <= rx;
          STEP_RD_B: save_b <= rx;
          STEP_RD_CAL: CAL_NORM <= {4'h0, cal_q} - CAL_NORM_OFFSET;
          STEP_RD_MODE: save_mode <= rx;
          STEP_RD_HIGH: temp_hi <= rx;
          STEP_RD_LOW: begin
            TEMP_RAW <= temp_now;
            TEMP_VALID <= 1'b1;
            seeded <= 1'b1;
            // First reading seeds the filter; later ones move a tenth of the way.
            TEMP_FILT <= seeded ? filt_next[TEMP_W-1:0] : temp_now;
            GRAY_INTEG_X10 <= SENS_FACTOR_X10;
          end
          default: seeded <= seeded;
        endcase
      end
    end
  end
endmodule

// *** bench/tsr_spi_props.sv ***
`timescale 1ns/100ps
module tsr_spi_props (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Serial wire.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic sclk_q;
  logic [4:0] rise_cnt;
  wire rise_now = sclk && !sclk_q;

  // Counts serial clock rises inside a frame, so framing can be judged at close.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_q <= 1'b0;
      rise_cnt <= 5'h00;
    end else begin
      sclk_q <= sclk;
      rise_cnt <= cs_n ? 5'h00 : rise_cnt + {4'h0, rise_now};
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_open;
    $fell(cs_n) ##1 !cs_n [*8];
  endsequence
  sequence s_first_rise;
    !sclk ##[1:2] $rose(sclk);
  endsequence

  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_rise_in_frame: assert property ($rose(sclk) |-> !cs_n)
    else $error("serial clock rose while deselected");
  a_half_period: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("serial clock high phase not two cycles");
  a_mosi_held: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while serial clock high");
  a_header_pad: assert property (rise_now && rise_cnt inside {[5'h01:5'h04]} |-> !mosi)
    else $error("header pad bit not zero");
  a_frame_bits: assert property ($rose(cs_n) |-> rise_cnt == 5'h18)
    else $error("frame did not carry 24 bits");
  a_frame_gap: assert property ($rose(cs_n) |=> cs_n)
    else $error("select high for less than two cycles");
  a_first_edge: assert property ($fell(cs_n) |-> s_first_rise)
    else $error("first serial clock rise late");
  a_frame_length: assert property (s_open |-> ##[50:120] $rose(cs_n))
    else $error("frame did not close in time");
endmodule

// *** bench/tb.sv ***
`timescale 1ns/100ps
module tb;
  import tsr_pkg::*;
  // Calibration byte is arbitrary, chosen away from the default.
  localparam logic [7:0] CAL = 8'hC3;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic FRAME_START = 1'b0;
  logic ROW_PAIR_DONE = 1'b0;
  logic [TEMP_W-1:0] SENSOR_TEMP = TEMP_RESET;
  logic INIT_REQ = 1'b0;
  logic TEMP_REQ = 1'b0;
  logic ROW_READ = 1'b0;
  logic ACQ_TRIGGER, LOW_SENSITIVITY, TEMP_READY, BUSY, TEMP_VALID;
  logic [7:0] MODE, SETTING_A, SETTING_B, GRAY_INTEG_X10;
  logic [TEMP_W-1:0] TEMP_RAW, TEMP_FILT;
  logic [15:0] CAL_NORM;
  int miscompares = 0;
  int checked = 0;
  int trig_cnt = 0;
  int valid_cnt = 0;
  int y = 0;
  bit seeded = 0;

  always #20 CLK = ~CLK;
  always @(posedge CLK) if (ACQ_TRIGGER === 1'b1) trig_cnt++;
  always @(posedge CLK) if (TEMP_VALID === 1'b1) valid_cnt++;

  tsr_spi_if spi ();
  tsr_device #(.CAL_FACTORY(CAL)) tsr_device_i (.CLK(CLK), .RST(RST), .SPI(spi),
    .FRAME_START(FRAME_START), .ROW_PAIR_DONE(ROW_PAIR_DONE), .SENSOR_TEMP(SENSOR_TEMP),
    .ACQ_TRIGGER(ACQ_TRIGGER), .LOW_SENSITIVITY(LOW_SENSITIVITY), .TEMP_READY(TEMP_READY),
    .MODE(MODE), .SETTING_A(SETTING_A), .SETTING_B(SETTING_B));
  tsr_host tsr_host_i (.CLK(CLK), .RST(RST), .SPI(spi), .INIT_REQ(INIT_REQ),
    .TEMP_REQ(TEMP_REQ), .ROW_READ(ROW_READ), .BUSY(BUSY), .TEMP_VALID(TEMP_VALID),
    .TEMP_RAW(TEMP_RAW), .TEMP_FILT(TEMP_FILT), .CAL_NORM(CAL_NORM),
    .GRAY_INTEG_X10(GRAY_INTEG_X10));
  tsr_spi_props tsr_spi_props_i (.CLK(CLK), .RST(RST), .sclk(spi.sclk), .cs_n(spi.cs_n),
    .mosi(spi.mosi), .miso(spi.miso));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge CLK) RST <= 1'b1;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
  endtask

  // Waits for the host to go idle, or for the reduced-sensitivity capture to arm.
  task automatic wait_until(input bit idle);
    for (int n = 0; n < 3000; n++) begin
      @(negedge CLK);
      if (idle ? (BUSY === 1'b0) : (LOW_SENSITIVITY === 1'b1)) return;
    end
    check(16'h0001, 16'h0000, "wait timed out");
  endtask

  task automatic test_init();
    logic [15:0] exp;
    exp = 16'((32'(CAL) * 10) / 47) - 16'h012B;
    for (int k = 0; k < 2; k++) begin
      @(posedge CLK) INIT_REQ <= 1'b1;
      @(posedge CLK) INIT_REQ <= 1'b0;
      wait_until(1'b1);
      check(CAL_NORM, exp, "normalised calibration");
      if (k == 0) begin
        do_reset();
        @(negedge CLK);
        check(CAL_NORM, 16'h0000, "calibration cleared by reset");
        check({MODE, SETTING_A}, 16'h0000, "mode and setting after reset");
      end
    end
    $display("test init done");
  endtask

  task automatic test_temp(input logic [TEMP_W-1:0] t);
    int n0;
    int v0;
    n0 = trig_cnt;
    v0 = valid_cnt;
    check({15'h0, LOW_SENSITIVITY}, 16'h0000, "normal sensitivity before trigger");
    @(posedge CLK) SENSOR_TEMP <= t;
    TEMP_REQ <= 1'b1;
    @(posedge CLK) TEMP_REQ <= 1'b0;
    wait_until(1'b0);
    check({15'h0, ACQ_TRIGGER}, 16'h0001, "trigger pulse with capture");
    check({8'h00, MODE}, {8'h00, MODE_GRAYSCALE}, "grayscale mode during capture");
    check({15'h0, LOW_SENSITIVITY}, 16'h0001, "reduced sensitivity");
    @(posedge CLK) FRAME_START <= 1'b1;
    @(posedge CLK) FRAME_START <= 1'b0;
    // The third pair must not yet capture; only the fourth counts in grayscale.
    for (int i = 0; i < 4; i++) begin
      @(negedge CLK);
      check({15'h0, TEMP_READY}, 16'h0000, "result too early");
      @(posedge CLK) ROW_PAIR_DONE <= 1'b1;
      ROW_READ <= 1'b1;
      @(posedge CLK) ROW_PAIR_DONE <= 1'b0;
      ROW_READ <= 1'b0;
    end
    @(negedge CLK);
    check({15'h0, TEMP_READY}, 16'h0001, "result after fourth pair");
    // A new frame between the two byte reads must not tear the pair.
    @(posedge spi.cs_n);
    @(posedge CLK) FRAME_START <= 1'b1;
    @(posedge CLK) FRAME_START <= 1'b0;
    @(negedge CLK);
    check({15'h0, TEMP_READY}, 16'h0000, "result cleared by frame start");
    wait_until(1'b1);
    if (!seeded) y = int'(t);
    else y = y + (int'(t) - y) / 10;
    seeded = 1;
    check({2'h0, TEMP_RAW}, {2'h0, t}, "temperature read back");
    check({2'h0, TEMP_FILT}, 16'(y), "filtered temperature");
    check({8'h00, GRAY_INTEG_X10}, 16'h0019, "integration stretch");
    check({8'h00, MODE}, 16'h0000, "mode restored");
    check({SETTING_A, SETTING_B}, 16'h0000, "settings restored");
    check(16'(trig_cnt - n0), 16'h0001, "one trigger pulse");
    check(16'(valid_cnt - v0), 16'h0001, "one result pulse");
    $display("test temperature %h done", t);
  endtask

  initial begin
    #(40 * 20000);
    miscompares++;
    give_verdict();
  end

  initial begin
    do_reset();
    test_init();
    test_temp(14'h2A5C);
    test_temp(14'h0F00);
    give_verdict();
  end
endmodule
